// *** rtl/dcd_pkg.sv ***
// How it works
// - Reference prescaler divides master clock by 1, 2, 4 or 8 for the mux.
// - Main prescaler divides master clock by 1, 2, 4 or 8; feeds main pin or divider.
// - Programmable divider divides main prescaler output by 2 through 1025.
// - A bypass bit routes the main prescaler straight to the main pin.
// - Divisor word holds the ratio; main frequency follows prescaler and divisor.
// - Reference pin is muxed between undivided master and prescaled clock.
// - Enable, select and sleep bits pick the reference control pin's role.
// - All three bits 0: reference output off; control pin high sleeps device.
// - Enable 0, select 1: control pin selects prescaled (high) or master (low).
// - Enable 1: control high disables output; low drives clock chosen by select.
// - Reference sleep bit 1: control high sleeps device and disables output.
// - Main control pin: output enable, or sleep request when main sleep bit set.
// - Sleep requests of both control pins are ORed into one device sleep.
// - Stored prescaler, divider and mode settings load from NV at power-up.
// - Device runs standalone from stored settings with no register traffic.
// - Host sets ratios and modes; new settings apply while running.
// - Configuration is three words: mode, divisor and bus settings.
// - Programmed values are copied to NV automatically or on request.
// - Prescaler code 00/01/10/11 means divide by 1/2/4/8.
// - Ten-bit divisor field gives ratio of programmed value plus two.
// - Bypass bit 1 ignores the divisor; 0 (default) runs it normally.
// - Enables wait for output low; sleep disables outputs first; 8000-cycle start.
package dcd_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_BUS = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;

  // Mode word fields
  localparam int MODE_MAIN_SLEEP = 14;
  localparam int MODE_REF_SLEEP = 13;
  localparam int MODE_REF_CHOOSE = 12;
  localparam int MODE_REF_GATE = 11;
  localparam int MODE_REF_SCALE_HI = 10;
  localparam int MODE_REF_SCALE_LO = 9;
  localparam int MODE_MAIN_SCALE_HI = 8;
  localparam int MODE_MAIN_SCALE_LO = 7;
  localparam int MODE_BYPASS = 6;
  localparam logic [15:0] MODE_WMASK = 16'h7fc0;
  localparam logic [15:0] MODE_RESET = 16'h1800;

  // Divisor word: ten-bit field in the top bits
  localparam int DIV_LSB = 6;
  localparam int DIV_W = 10;
  localparam logic [15:0] DIV_WMASK = 16'hffc0;
  localparam logic [15:0] DIV_RESET = 16'h0000;

  // Bus settings word
  localparam int BUS_WCTRL = 3;
  localparam logic [7:0] BUS_WMASK = 8'h0f;
  localparam logic [7:0] BUS_RESET = 8'h00;

  // Command register: store request
  localparam int CMD_STORE = 0;

  // Status register bits
  localparam int STAT_SLEEP = 0;
  localparam int STAT_READY = 1;
  localparam int STAT_REF_OE = 2;
  localparam int STAT_MAIN_OE = 3;

  // Start-up hold-off in master clock cycles
  localparam int STARTUP_CYCLES = 8000;

  // Offset added to the divisor field
  localparam logic [10:0] DIV_OFFSET = 11'h002;

  typedef enum logic [4:0] {
    ST_LOAD = 5'b00001,
    ST_START = 5'b00010,
    ST_RUN = 5'b00100,
    ST_DRAIN = 5'b01000,
    ST_SLEEP = 5'b10000
  } dcd_state_e;

endpackage

// *** rtl/dcd_divider.sv ***
// Divides a stream of half-period ticks by a ratio; the new ratio is taken
// only at a wrap, so an output half-period is never cut short.
module dcd_divider #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Incoming half-period ticks and requested ratio minus one
  input wire logic i_tick,
  input wire logic [W-1:0] i_ratio_m1,
  // Outgoing half-period tick and square wave
  output logic o_tick,
  output logic o_level
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] ratio_q;
  logic [W-1:0] ratio_d;
  logic level_q;
  logic level_d;
  logic wrap;

  // Count ticks, reload ratio at the wrap only
  always_comb
  begin
    wrap = i_tick && (cnt_q == ratio_q);
    cnt_d = cnt_q;
    ratio_d = ratio_q;
    level_d = level_q;
    if (wrap)
    begin
      cnt_d = '0;
      ratio_d = i_ratio_m1;
      level_d = ~level_q;
    end
    else if (i_tick)
    begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= '0;
      ratio_q <= '0;
      level_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      ratio_q <= ratio_d;
      level_q <= level_d;
    end
  end

  assign o_tick = wrap;
  assign o_level = level_q;

endmodule

// *** rtl/dcd_top.sv ***
// Dual-output clock divider: reference and main outputs with control pins,
// power sequencing, register port and nonvolatile settings store.
//
// Chosen here: the register offsets and the address-and-strobe port.
module dcd_top #(
  parameter int STARTUP_CYCLES = dcd_pkg::STARTUP_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Control pins
  input wire logic i_ref_control_pin,
  input wire logic i_main_control_pin,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Stored settings from the nonvolatile array
  input wire logic [15:0] i_nv_mode,
  input wire logic [15:0] i_nv_div,
  input wire logic [7:0] i_nv_bus,
  // Store request to the nonvolatile array
  output logic o_nv_wr,
  output logic [15:0] o_nv_mode,
  output logic [15:0] o_nv_div,
  output logic [7:0] o_nv_bus,
  // Clock outputs, each with its enable
  output logic o_ref_clock_pin,
  output logic o_ref_clock_pin_oe,
  output logic o_main_clock_pin,
  output logic o_main_clock_pin_oe,
  // Device status
  output logic o_sleep
);

  localparam int CW = $clog2(STARTUP_CYCLES + 1);

  // Prescaler code to ratio minus one
  function automatic logic [2:0] scale_m1(input logic [1:0] code);
    unique case (code)
      2'b00: scale_m1 = 3'h0;
      2'b01: scale_m1 = 3'h1;
      2'b10: scale_m1 = 3'h3;
      2'b11: scale_m1 = 3'h7;
    endcase
  endfunction

  // A source may be switched only while both candidates sit low
  function automatic logic quiet(input logic a, input logic b);
    quiet = !a && !b;
  endfunction

  // Settings registers
  logic [15:0] mode_q;
  logic [15:0] mode_d;
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic [7:0] bus_q;
  logic [7:0] bus_d;
  logic nv_wr_q;
  logic nv_wr_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // Power sequencing
  dcd_pkg::dcd_state_e state_q;
  dcd_pkg::dcd_state_e state_d;
  logic [CW-1:0] start_cnt_q;
  logic [CW-1:0] start_cnt_d;

  // Clock path
  logic run;
  logic master_q;
  logic master_d;
  logic ref_pre_level;
  logic main_pre_tick;
  logic main_pre_level;
  logic ratio_level;
  logic ref_sel_q;
  logic ref_sel_d;
  logic bypass_q;
  logic bypass_d;
  logic ref_clk_q;
  logic ref_clk_d;
  logic main_clk_q;
  logic main_clk_d;
  logic ref_oe_q;
  logic ref_oe_d;
  logic main_oe_q;
  logic main_oe_d;

  // Decoded control pin roles
  logic ref_want_oe;
  logic ref_want_pre;
  logic main_want_oe;
  logic sleep_req;
  logic [10:0] ratio_m1;

  // Field aliases
  logic ref_gate_cfg;
  logic ref_choose_cfg;
  logic ref_sleep_cfg;
  logic main_sleep_cfg;
  logic ratio_bypass;
  logic [1:0] ref_scale_code;
  logic [1:0] main_scale_code;
  localparam int DIV_W_L = dcd_pkg::DIV_W;
  logic [DIV_W_L-1:0] ratio_field;

  assign ref_gate_cfg = mode_q[dcd_pkg::MODE_REF_GATE];
  assign ref_choose_cfg = mode_q[dcd_pkg::MODE_REF_CHOOSE];
  assign ref_sleep_cfg = mode_q[dcd_pkg::MODE_REF_SLEEP];
  assign main_sleep_cfg = mode_q[dcd_pkg::MODE_MAIN_SLEEP];
  assign ratio_bypass = mode_q[dcd_pkg::MODE_BYPASS];
  assign ref_scale_code = {mode_q[dcd_pkg::MODE_REF_SCALE_HI],
                           mode_q[dcd_pkg::MODE_REF_SCALE_LO]};
  assign main_scale_code = {mode_q[dcd_pkg::MODE_MAIN_SCALE_HI],
                            mode_q[dcd_pkg::MODE_MAIN_SCALE_LO]};
  assign ratio_field = div_q[dcd_pkg::DIV_LSB +: DIV_W_L];
  // Ratio minus one is field plus one, at most 1024
  assign ratio_m1 = 11'(ratio_field) + dcd_pkg::DIV_OFFSET - 11'h001;

  // Control pin roles from the mode bits
  always_comb
  begin
    ref_want_oe = 1'b0;
    ref_want_pre = ref_choose_cfg;
    sleep_req = 1'b0;
    if (ref_sleep_cfg)
    begin
      sleep_req = i_ref_control_pin;
      ref_want_oe = !i_ref_control_pin;
    end
    else if (ref_gate_cfg)
    begin
      ref_want_oe = !i_ref_control_pin;
    end
    else if (ref_choose_cfg)
    begin
      ref_want_oe = 1'b1;
      ref_want_pre = i_ref_control_pin;
    end
    else
    begin
      sleep_req = i_ref_control_pin;
    end
    // role picked above; main pin below
    main_want_oe = !i_main_control_pin;
    if (main_sleep_cfg && i_main_control_pin)
    begin
      sleep_req = 1'b1;
    end
  end

  // Power sequencing: load, start-up hold, run, drain, sleep
  always_comb
  begin
    state_d = state_q;
    start_cnt_d = start_cnt_q;
    unique case (state_q)
      dcd_pkg::ST_LOAD:
      begin
        state_d = dcd_pkg::ST_START;
        start_cnt_d = '0;
      end
      dcd_pkg::ST_START:
      begin
        start_cnt_d = start_cnt_q + CW'(1);
        // Outputs are still off here, so there is nothing to drain, and
        // a dropped request restarts the full settle time
        if (sleep_req)
          state_d = dcd_pkg::ST_SLEEP;
        else if (start_cnt_q == CW'(STARTUP_CYCLES - 1))
          state_d = dcd_pkg::ST_RUN;
      end
      dcd_pkg::ST_RUN:
      begin
        if (sleep_req)
          state_d = dcd_pkg::ST_DRAIN;
      end
      dcd_pkg::ST_DRAIN:
      begin
        // Outputs are released first so no pin is cut mid-pulse
        if (!sleep_req)
          state_d = dcd_pkg::ST_RUN;
        else if (!ref_oe_q && !main_oe_q)
          state_d = dcd_pkg::ST_SLEEP;
      end
      dcd_pkg::ST_SLEEP:
      begin
        if (!sleep_req)
        begin
          state_d = dcd_pkg::ST_START;  // Oscillator must settle again
          start_cnt_d = '0;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= dcd_pkg::ST_LOAD;
      start_cnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      start_cnt_q <= start_cnt_d;
    end
  end

  // Generators run in every state but load and sleep
  assign run = (state_q != dcd_pkg::ST_LOAD) &&
               (state_q != dcd_pkg::ST_SLEEP);

  // Reference prescaler
  dcd_divider #(
    .W(3)
  ) u_ref_prescaler (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_tick(run),
    .i_ratio_m1(scale_m1(ref_scale_code)),
    .o_tick(),
    .o_level(ref_pre_level)
  );

  // Main prescaler
  dcd_divider #(
    .W(3)
  ) u_main_prescaler (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_tick(run),
    .i_ratio_m1(scale_m1(main_scale_code)),
    .o_tick(main_pre_tick),
    .o_level(main_pre_level)
  );

  // Programmable ratio divider after the main prescaler
  dcd_divider #(
    .W(11)
  ) u_ratio (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_tick(main_pre_tick),
    .i_ratio_m1(ratio_m1),
    .o_tick(),
    .o_level(ratio_level)
  );

  // Output muxes and glitch-free enables
  always_comb
  begin
    master_d = run ? ~master_q : master_q;
    ref_sel_d = ref_sel_q;
    bypass_d = bypass_q;
    // Select moves only when both sources are low: no runt pulse
    if (quiet(master_q, ref_pre_level))
      ref_sel_d = ref_want_pre;
    if (quiet(main_pre_level, ratio_level))
      bypass_d = ratio_bypass;
    ref_clk_d = ref_sel_q ? ref_pre_level : master_q;
    main_clk_d = bypass_q ? main_pre_level : ratio_level;
    ref_oe_d = ref_oe_q;
    main_oe_d = main_oe_q;
    // Enables flip only while the pin is low
    if (!ref_clk_q)
      ref_oe_d = ref_want_oe && (state_q == dcd_pkg::ST_RUN);
    if (!main_clk_q)
      main_oe_d = main_want_oe && (state_q == dcd_pkg::ST_RUN);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      master_q <= 1'b0;
      ref_sel_q <= 1'b1;
      bypass_q <= 1'b0;
      ref_clk_q <= 1'b0;
      main_clk_q <= 1'b0;
      ref_oe_q <= 1'b0;
      main_oe_q <= 1'b0;
    end
    else
    begin
      master_q <= master_d;
      ref_sel_q <= ref_sel_d;
      bypass_q <= bypass_d;
      ref_clk_q <= ref_clk_d;
      main_clk_q <= main_clk_d;
      ref_oe_q <= ref_oe_d;
      main_oe_q <= main_oe_d;
    end
  end

  // Settings words, register port and store requests
  always_comb
  begin
    mode_d = mode_q;
    div_d = div_q;
    bus_d = bus_q;
    nv_wr_d = 1'b0;
    rdata_d = 16'h0000;
    if (state_q == dcd_pkg::ST_LOAD)
    begin
      // Stored words become the working settings
      mode_d = i_nv_mode & dcd_pkg::MODE_WMASK;
      div_d = i_nv_div & dcd_pkg::DIV_WMASK;
      bus_d = i_nv_bus & dcd_pkg::BUS_WMASK;
    end
    else if (i_wr && state_q != dcd_pkg::ST_SLEEP)
    begin
      // Writes apply at once while running; ignored while asleep
      unique case (i_addr)
        dcd_pkg::ADDR_MODE:
        begin
          mode_d = i_wdata & dcd_pkg::MODE_WMASK;
          nv_wr_d = !bus_q[dcd_pkg::BUS_WCTRL];
        end
        dcd_pkg::ADDR_DIV:
        begin
          div_d = i_wdata & dcd_pkg::DIV_WMASK;
          nv_wr_d = !bus_q[dcd_pkg::BUS_WCTRL];
        end
        dcd_pkg::ADDR_BUS:
        begin
          bus_d = i_wdata[7:0] & dcd_pkg::BUS_WMASK;
          nv_wr_d = 1'b1;
        end
        dcd_pkg::ADDR_CMD:
          nv_wr_d = i_wdata[dcd_pkg::CMD_STORE];
        default:
          nv_wr_d = 1'b0;
      endcase
    end
    if (i_rd)
    begin
      unique case (i_addr)
        dcd_pkg::ADDR_MODE: rdata_d = mode_q;
        dcd_pkg::ADDR_DIV: rdata_d = div_q;
        dcd_pkg::ADDR_BUS: rdata_d = {8'h00, bus_q};
        dcd_pkg::ADDR_STAT:
        begin
          rdata_d[dcd_pkg::STAT_SLEEP] = (state_q == dcd_pkg::ST_SLEEP);
          rdata_d[dcd_pkg::STAT_READY] = (state_q == dcd_pkg::ST_RUN);
          rdata_d[dcd_pkg::STAT_REF_OE] = ref_oe_q;
          rdata_d[dcd_pkg::STAT_MAIN_OE] = main_oe_q;
        end
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mode_q <= dcd_pkg::MODE_RESET;
      div_q <= dcd_pkg::DIV_RESET;
      bus_q <= dcd_pkg::BUS_RESET;
      nv_wr_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      mode_q <= mode_d;
      div_q <= div_d;
      bus_q <= bus_d;
      nv_wr_q <= nv_wr_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs, all from flip-flops
  assign o_rdata = rdata_q;
  assign o_nv_wr = nv_wr_q;
  assign o_nv_mode = mode_q;
  assign o_nv_div = div_q;
  assign o_nv_bus = bus_q;
  assign o_ref_clock_pin = ref_clk_q;
  assign o_ref_clock_pin_oe = ref_oe_q;
  assign o_main_clock_pin = main_clk_q;
  assign o_main_clock_pin_oe = main_oe_q;
  // Sleep flag from the state register
  assign o_sleep = (state_q == dcd_pkg::ST_SLEEP);

endmodule

// *** verification/dcd_props.sv ***
// Watches the top ports; all checks live in the one master clock domain
module dcd_props #(
  parameter int STARTUP_CYCLES = dcd_pkg::STARTUP_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Pins and register port
  input wire logic i_ref_control_pin,
  input wire logic i_main_control_pin,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_nv_wr,
  // Clock outputs and status
  input wire logic o_ref_clock_pin,
  input wire logic o_ref_clock_pin_oe,
  input wire logic o_main_clock_pin,
  input wire logic o_main_clock_pin_oe,
  input wire logic o_sleep
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  // Cycles since reset, saturating so it never wraps on a long run
  int up_q;
  int up_d;
  always_comb up_d = (up_q > STARTUP_CYCLES) ? up_q : up_q + 1;
  always_ff @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n)
      up_q <= 0;
    else
      up_q <= up_d;

  sequence s_bus_wr;
    i_wr && i_addr == dcd_pkg::ADDR_BUS && !o_sleep;
  endsequence
  sequence s_main_off;
    !o_main_clock_pin_oe || !i_main_control_pin;
  endsequence

  property p_ref_oe_low;
    $changed(o_ref_clock_pin_oe) |-> !$past(o_ref_clock_pin);
  endproperty
  property p_main_oe_low;
    $changed(o_main_clock_pin_oe) |-> !$past(o_main_clock_pin);
  endproperty
  property p_sleep_off;
    o_sleep |-> !o_ref_clock_pin_oe && !o_main_clock_pin_oe;
  endproperty
  property p_sleep_cause;
    o_sleep |-> $past(i_ref_control_pin) || $past(i_main_control_pin);
  endproperty
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 16'h0000;
  endproperty
  property p_store_cause;
    o_nv_wr |-> $past(i_wr);
  endproperty
  property p_bus_store;
    s_bus_wr |=> o_nv_wr;
  endproperty
  property p_asleep_nowr;
    o_sleep && i_wr |=> !o_nv_wr;
  endproperty
  property p_startup;
    o_ref_clock_pin_oe || o_main_clock_pin_oe |-> up_q > STARTUP_CYCLES;
  endproperty
  // The wait for a low level bounds the delay by one output half-period
  property p_main_disable;
    $rose(i_main_control_pin) |-> ##[0:1000] s_main_off;
  endproperty

  a_ref_oe_low: assert property (p_ref_oe_low)
    else $error("ref enable moved while pin high");
  a_main_oe_low: assert property (p_main_oe_low)
    else $error("main enable moved while pin high");
  a_sleep_off: assert property (p_sleep_off)
    else $error("output enabled while asleep");
  a_sleep_cause: assert property (p_sleep_cause)
    else $error("asleep with no control pin high");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read");
  a_store_cause: assert property (p_store_cause)
    else $error("store without a write");
  a_bus_store: assert property (p_bus_store)
    else $error("bus word write did not store");
  a_asleep_nowr: assert property (p_asleep_nowr)
    else $error("write taken while asleep");
  a_startup: assert property (p_startup)
    else $error("output enabled before start-up delay");
  a_main_disable: assert property (p_main_disable)
    else $error("main output not disabled");
endmodule

bind dcd_top dcd_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) dcd_props_i (
  .i_mclk(i_mclk),
  .i_rst_n(i_rst_n),
  .i_ref_control_pin(i_ref_control_pin),
  .i_main_control_pin(i_main_control_pin),
  .i_addr(i_addr),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_nv_wr(o_nv_wr),
  .o_ref_clock_pin(o_ref_clock_pin),
  .o_ref_clock_pin_oe(o_ref_clock_pin_oe),
  .o_main_clock_pin(o_main_clock_pin),
  .o_main_clock_pin_oe(o_main_clock_pin_oe),
  .o_sleep(o_sleep)
);

// *** verification/dcd_nv_model.sv ***
// Nonvolatile array: holds the stored words and counts store requests
module dcd_nv_model #(
  parameter logic [15:0] MODE_INIT = 16'h1800,
  parameter logic [15:0] DIV_INIT = 16'h0000
) (
  // Clock and store request
  input wire logic i_mclk,
  input wire logic i_wr,
  input wire logic [15:0] i_mode,
  input wire logic [15:0] i_div,
  input wire logic [7:0] i_bus,
  // Stored words and store count
  output logic [15:0] o_mode,
  output logic [15:0] o_div,
  output logic [7:0] o_bus,
  output logic [15:0] o_count
);
  // Words are valid from time zero, before reset is released
  initial
  begin
    o_mode = MODE_INIT;
    o_div = DIV_INIT;
    o_bus = 8'h00;
    o_count = 16'h0000;
  end

  // Capture the working words on each store pulse
  always @(posedge i_mclk)
    if (i_wr)
    begin
      o_mode <= i_mode;
      o_div <= i_div;
      o_bus <= i_bus;
      o_count <= o_count + 16'h0001;
    end
endmodule

// *** verification/dcd_top_test.sv ***
module dcd_top_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic i_mclk, i_rst_n, i_ref_control_pin, i_main_control_pin, i_wr, i_rd;
  logic [7:0] i_addr, o_nv_bus, nv_bus;
  logic [15:0] i_wdata, o_rdata, o_nv_mode, o_nv_div, nv_mode, nv_div, nvc;
  logic o_nv_wr, o_ref_clock_pin, o_ref_clock_pin_oe;
  logic o_main_clock_pin, o_main_clock_pin_oe, o_sleep;
  int mismatches, cmp_count;

  dcd_top #(.STARTUP_CYCLES(16)) dcd_top_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_ref_control_pin(i_ref_control_pin),
    .i_main_control_pin(i_main_control_pin),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_nv_mode(nv_mode), .i_nv_div(nv_div),
    .i_nv_bus(nv_bus), .o_nv_wr(o_nv_wr), .o_nv_mode(o_nv_mode),
    .o_nv_div(o_nv_div), .o_nv_bus(o_nv_bus),
    .o_ref_clock_pin(o_ref_clock_pin),
    .o_ref_clock_pin_oe(o_ref_clock_pin_oe),
    .o_main_clock_pin(o_main_clock_pin),
    .o_main_clock_pin_oe(o_main_clock_pin_oe), .o_sleep(o_sleep));

  // Stored settings: ref prescale by 4, main by 2, divisor field 1
  dcd_nv_model #(.MODE_INIT(16'h1c80), .DIV_INIT(16'h0040)) dcd_nv_model_i (
    .i_mclk(i_mclk), .i_wr(o_nv_wr), .i_mode(o_nv_mode), .i_div(o_nv_div),
    .i_bus(o_nv_bus), .o_mode(nv_mode), .o_div(nv_div), .o_bus(nv_bus),
    .o_count(nvc));

  // Master clock, 100 ns period
  initial
  begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [15:0] md(input int g, c, rs, ms, byp, rc, mc);
    md = 16'h0000;
    md[dcd_pkg::MODE_REF_GATE] = g[0];
    md[dcd_pkg::MODE_REF_CHOOSE] = c[0];
    md[dcd_pkg::MODE_REF_SLEEP] = rs[0];
    md[dcd_pkg::MODE_MAIN_SLEEP] = ms[0];
    md[dcd_pkg::MODE_BYPASS] = byp[0];
    md[dcd_pkg::MODE_REF_SCALE_HI -: 2] = rc[1:0];
    md[dcd_pkg::MODE_MAIN_SCALE_HI -: 2] = mc[1:0];
  endfunction

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk("read data", e, o_rdata);
  endtask

  function automatic logic sg(input int s);
    case (s)
      0: sg = o_sleep;
      1: sg = o_ref_clock_pin_oe;
      default: sg = o_main_clock_pin_oe;
    endcase
  endfunction

  // Bounded wait for a status signal, then compare it
  task automatic ewait(input int s, input logic v);
    int k;
    for (k = 0; k < 400 && sg(s) !== v; k++)
      @(negedge i_mclk);
    chk($sformatf("status %0d", s), {15'h0000, v}, {15'h0000, sg(s)});
  endtask

  // Length of one high phase of an output, in master cycles
  task automatic half(input int s, input int e);
    int k, n;
    logic p, l;
    repeat (40) @(posedge i_mclk);
    l = 1'b1;
    n = 0;
    for (k = 0; k < 6000; k++)
    begin
      @(negedge i_mclk);
      p = s ? o_main_clock_pin : o_ref_clock_pin;
      if (n > 0 && !p)
        break;
      if (n > 0 || (!l && p))
        n++;
      l = p;
    end
    chk(s ? "main half" : "ref half", e[15:0], n[15:0]);
  endtask

  task automatic pins(input logic r, input logic m);
    @(posedge i_mclk);
    i_ref_control_pin <= r;
    i_main_control_pin <= m;
  endtask

  task automatic stores(input logic [15:0] e);
    repeat (3) @(posedge i_mclk);
    chk("store count", e, nvc);
  endtask

  // Hang guard, well beyond the expected run
  initial
  begin
    #6000000;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    int c;
    logic [15:0] s;
    {i_rst_n, i_ref_control_pin, i_main_control_pin, i_wr, i_rd} = 5'h00;
    i_addr = 8'h00;
    i_wdata = 16'h0000;
    mismatches = 0;
    cmp_count = 0;
    repeat (5) @(posedge i_mclk);
    chk("reset mode", 16'h1800, o_nv_mode);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    ewait(2, 1'b1);
    ewait(1, 1'b1);
    rchk(dcd_pkg::ADDR_MODE, 16'h1c80);
    rchk(dcd_pkg::ADDR_DIV, 16'h0040);
    half(1, 6);
    half(0, 4);
    rchk(8'h20, 16'h0000);
    for (c = 0; c < 4; c++)
    begin
      wr(dcd_pkg::ADDR_MODE, md(1, 1, 0, 0, 0, c, c));
      half(0, 1 << c);
      half(1, 3 << c);
      chk("stored mode", md(1, 1, 0, 0, 0, c, c), nv_mode);
    end
    wr(dcd_pkg::ADDR_DIV, 16'hffff);
    rchk(dcd_pkg::ADDR_DIV, 16'hffc0);
    wr(dcd_pkg::ADDR_MODE, md(1, 1, 0, 0, 0, 0, 0));
    half(1, 1025);
    wr(dcd_pkg::ADDR_DIV, 16'h0000);
    half(1, 2);
    wr(dcd_pkg::ADDR_MODE, md(1, 1, 0, 0, 1, 0, 2));
    half(1, 4);
    wr(dcd_pkg::ADDR_MODE, 16'hffff);
    rchk(dcd_pkg::ADDR_MODE, 16'h7fc0);
    wr(dcd_pkg::ADDR_MODE, md(0, 1, 0, 0, 0, 3, 0));
    pins(1'b1, 1'b0);
    half(0, 8);
    pins(1'b0, 1'b0);
    half(0, 1);
    wr(dcd_pkg::ADDR_MODE, md(1, 0, 0, 0, 0, 3, 0));
    half(0, 1);
    pins(1'b1, 1'b0);
    ewait(1, 1'b0);
    pins(1'b0, 1'b0);
    ewait(1, 1'b1);
    wr(dcd_pkg::ADDR_MODE, md(0, 0, 0, 0, 0, 0, 0));
    ewait(1, 1'b0);
    pins(1'b1, 1'b0);
    ewait(0, 1'b1);
    ewait(2, 1'b0);
    rchk(dcd_pkg::ADDR_STAT, 16'h0001);
    s = nvc;
    wr(dcd_pkg::ADDR_BUS, 16'h0000);
    stores(s);
    pins(1'b0, 1'b0);
    ewait(0, 1'b0);
    ewait(2, 1'b1);
    wr(dcd_pkg::ADDR_MODE, md(0, 1, 1, 0, 0, 0, 0));
    pins(1'b1, 1'b0);
    ewait(0, 1'b1);
    pins(1'b0, 1'b0);
    ewait(1, 1'b1);
    wr(dcd_pkg::ADDR_MODE, md(1, 1, 0, 1, 0, 0, 0));
    pins(1'b0, 1'b1);
    ewait(0, 1'b1);
    pins(1'b0, 1'b0);
    ewait(0, 1'b0);
    wr(dcd_pkg::ADDR_MODE, md(1, 1, 0, 0, 0, 0, 0));
    ewait(2, 1'b1);
    pins(1'b0, 1'b1);
    ewait(2, 1'b0);
    ewait(0, 1'b0);
    pins(1'b0, 1'b0);
    ewait(2, 1'b1);
    s = nvc;
    wr(dcd_pkg::ADDR_BUS, 16'h0008);
    stores(s + 16'h0001);
    wr(dcd_pkg::ADDR_MODE, md(1, 1, 0, 0, 0, 1, 1));
    stores(s + 16'h0001);
    wr(dcd_pkg::ADDR_CMD, 16'h0001);
    stores(s + 16'h0002);
    chk("stored mode", md(1, 1, 0, 0, 0, 1, 1), nv_mode);
    end_of_test();
  end
endmodule
